// ---- logic/dcc_pkg.sv ----
/*
 * constants for the debug comparator channel block: register indices,
 * control field positions, reset values and own register layout.
 * assumes a 32-bit apb slave, byte address equals four times the index.
 */
package dcc_pkg;
    // comparator window indices, byte address is index * 4
    localparam logic [7:0] IDX_CTL = 8'h28;
    localparam logic [7:0] IDX_AH = 8'h29;
    localparam logic [7:0] IDX_AM = 8'h2a;
    localparam logic [7:0] IDX_AL = 8'h2b;
    localparam logic [7:0] IDX_DH = 8'h2c;
    localparam logic [7:0] IDX_DL = 8'h2d;
    localparam logic [7:0] IDX_MH = 8'h2e;
    localparam logic [7:0] IDX_ML = 8'h2f;
    // block control, breakpoint enable and interrupt registers
    localparam logic [7:0] IDX_DBG_CTL = 8'h30;
    localparam logic [7:0] IDX_BRK_EN = 8'h31;
    localparam logic [7:0] IDX_IRQ_STAT = 8'h32;
    localparam logic [7:0] IDX_IRQ_CLR = 8'h33;
    localparam logic [7:0] IDX_IRQ_EN = 8'h34;
    // control register bit positions
    localparam int CTL_SIZE_EN = 7;
    localparam int CTL_SIZE_VAL = 6;
    localparam int CTL_NOT_DATA = 6;
    localparam int CTL_TAG = 5;
    localparam int CTL_BRK = 4;
    localparam int CTL_DIR_VAL = 3;
    localparam int CTL_DIR_EN = 2;
    localparam int CTL_ON = 0;
    // control bits implemented on data channels (bit 7 absent)
    localparam logic [7:0] CTL_MASK_DATA = 8'h7f;
    localparam logic [7:0] CTL_MASK_ADDR = 8'hff;
    // debug control register fields
    localparam int DC_VIEW_LSB = 0;
    localparam int DC_ARM = 2;
    // status bits: four channel matches then the break event
    localparam int ST_BREAK = 4;
    localparam int ST_W = 5;
    // reset values
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [6:0] AH_RST = 7'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    // view codes
    localparam logic [1:0] VIEW_A = 2'h0;
    localparam logic [1:0] VIEW_B = 2'h1;
    localparam logic [1:0] VIEW_C = 2'h2;
    localparam logic [1:0] VIEW_D = 2'h3;
endpackage : dcc_pkg

// ---- logic/dcc_match.sv ----
/*
 * match logic for one comparator channel: address, masked data,
 * direction and size qualifiers, plus opcode tagging.
 * assumes bus and execution inputs come from logic on mclk_i.
 */
`timescale 1ns/1ps
module dcc_match #(
    parameter bit HAS_DATA = 1'b1,
    parameter int AW = 23,
    parameter int DW = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [7:0] ctl_i,
    input wire logic [AW-1:0] cmp_addr_i,
    input wire logic [DW-1:0] cmp_data_i,
    input wire logic [DW-1:0] cmp_mask_i,
    input wire logic bus_valid_i,
    input wire logic [AW-1:0] bus_addr_i,
    input wire logic [DW-1:0] bus_data_i,
    input wire logic bus_read_i,
    input wire logic bus_byte_i,
    input wire logic exec_valid_i,
    input wire logic [AW-1:0] exec_addr_i,
    output logic hit_o
);
    logic tag_sel, addr_ok, data_ok, dir_ok, size_ok, raw, fire;
    logic tag_q;

    // qualifiers; tagging drops data, direction and size checks
    always_comb begin
        tag_sel = ctl_i[dcc_pkg::CTL_TAG];
        addr_ok = (bus_addr_i == cmp_addr_i);
        data_ok = !HAS_DATA || tag_sel
            || ((((bus_data_i ^ cmp_data_i) & cmp_mask_i) != '0)
                == ctl_i[dcc_pkg::CTL_NOT_DATA]);
        dir_ok = tag_sel || !ctl_i[dcc_pkg::CTL_DIR_EN]
            || (bus_read_i == ctl_i[dcc_pkg::CTL_DIR_VAL]);
        size_ok = HAS_DATA || tag_sel
            || !ctl_i[dcc_pkg::CTL_SIZE_EN]
            || (bus_byte_i == ctl_i[dcc_pkg::CTL_SIZE_VAL]);
        raw = ctl_i[dcc_pkg::CTL_ON] && bus_valid_i && addr_ok
            && data_ok && dir_ok && size_ok;
        fire = tag_q && exec_valid_i && (exec_addr_i == cmp_addr_i);
    end

    // opcode tag: set by a match, consumed when the opcode executes
    always_ff @(posedge mclk_i) begin
        if (rst_i || !ctl_i[dcc_pkg::CTL_ON] || !tag_sel) begin
            tag_q <= 1'b0;
        end else if (raw) begin
            tag_q <= 1'b1;
        end else if (fire) begin
            tag_q <= 1'b0;
        end
    end

    // registered channel trigger
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            hit_o <= 1'b0;
        end else begin
            hit_o <= tag_sel ? fire : raw;
        end
    end
endmodule : dcc_match

// ---- logic/dcc_top.sv ----
/*
 * debug comparator channel block: four comparators (a and c with data,
 * b and d address only) seen through one eight-byte window on apb,
 * arming, immediate break and a sticky interrupt status.
 * assumes the processor bus and execution stage run on mclk_i.
 */
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module dcc_top #(
    parameter int AW = 23,
    parameter int DW = 16
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic bus_valid_i,
    input wire logic [AW-1:0] bus_addr_i,
    input wire logic [DW-1:0] bus_data_i,
    input wire logic bus_read_i,
    input wire logic bus_byte_i,
    input wire logic exec_valid_i,
    input wire logic [AW-1:0] exec_addr_i,
    output logic [3:0] trigger_o,
    output logic break_o,
    output logic armed_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////
    // storage
    logic [7:0] ctl_q [4];
    logic [6:0] ah_q [4];
    logic [7:0] am_q [4];
    logic [7:0] al_q [4];
    logic [15:0] dat_q [2];
    logic [15:0] msk_q [2];
    logic [1:0] view_q;
    logic brk_en_q;
    logic [dcc_pkg::ST_W-1:0] stat_q;
    logic [dcc_pkg::ST_W-1:0] irq_en_q;
    logic [3:0] hit;
    logic brk_hit;

    ////////////////////////////////////////////////////////////////////
    // apb decode
    logic [7:0] idx;
    logic aligned, acc, wr, lane0;
    logic win, has_data, mapped;
    logic [1:0] ch;
    logic dch;

    // true for views that show a data comparator
    function automatic logic view_has_data(input logic [1:0] v);
        return (v == dcc_pkg::VIEW_A) || (v == dcc_pkg::VIEW_C);
    endfunction : view_has_data

    always_comb begin
        idx = paddr_i[9:2];
        aligned = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
        acc = psel_i && penable_i && pready_o;
        wr = acc && pwrite_i;
        lane0 = pstrb_i[0];
        ch = view_q;
        dch = view_q[1];
        has_data = view_has_data(view_q);
        win = (idx >= dcc_pkg::IDX_CTL) && (idx <= dcc_pkg::IDX_ML);
        mapped = aligned && (win || (idx >= dcc_pkg::IDX_DBG_CTL
            && idx <= dcc_pkg::IDX_IRQ_EN));
    end

    // comparator writes are blocked while armed
    logic cw;
    assign cw = wr && lane0 && aligned && !armed_o;

    ////////////////////////////////////////////////////////////////////
    // comparator registers
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) begin
                ctl_q[i] <= dcc_pkg::CTL_RST;
                ah_q[i] <= dcc_pkg::AH_RST;
                am_q[i] <= dcc_pkg::BYTE_RST;
                al_q[i] <= dcc_pkg::BYTE_RST;
            end
        end else if (cw) begin
            case (idx)
                dcc_pkg::IDX_CTL: begin
                    ctl_q[ch] <= pwdata_i[7:0] & (has_data
                        ? dcc_pkg::CTL_MASK_DATA
                        : dcc_pkg::CTL_MASK_ADDR);
                end
                dcc_pkg::IDX_AH: ah_q[ch] <= pwdata_i[6:0];
                dcc_pkg::IDX_AM: am_q[ch] <= pwdata_i[7:0];
                dcc_pkg::IDX_AL: al_q[ch] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    // data and mask bytes exist only behind data views
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 2; i++) begin
                dat_q[i] <= {dcc_pkg::BYTE_RST, dcc_pkg::BYTE_RST};
                msk_q[i] <= {dcc_pkg::BYTE_RST, dcc_pkg::BYTE_RST};
            end
        end else if (cw && has_data) begin
            case (idx)
                dcc_pkg::IDX_DH: dat_q[dch][15:8] <= pwdata_i[7:0];
                dcc_pkg::IDX_DL: dat_q[dch][7:0] <= pwdata_i[7:0];
                dcc_pkg::IDX_MH: msk_q[dch][15:8] <= pwdata_i[7:0];
                dcc_pkg::IDX_ML: msk_q[dch][7:0] <= pwdata_i[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // block control: view select, arming and breakpoint enable
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            view_q <= dcc_pkg::VIEW_A;
            brk_en_q <= 1'b0;
        end else if (wr && lane0 && aligned) begin
            if (idx == dcc_pkg::IDX_DBG_CTL) begin
                view_q <= pwdata_i[dcc_pkg::DC_VIEW_LSB +: 2];
            end
            if (idx == dcc_pkg::IDX_BRK_EN) begin
                brk_en_q <= pwdata_i[0];
            end
        end
    end

    // software arms and disarms; a break disarms unless written same cycle
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            armed_o <= 1'b0;
        end else if (wr && lane0 && aligned
                     && idx == dcc_pkg::IDX_DBG_CTL) begin
            armed_o <= pwdata_i[dcc_pkg::DC_ARM];
        end else if (brk_hit) begin
            armed_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // the four match channels
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_ch
            localparam bit HD = (g == 0) || (g == 2);
            dcc_match #(
                .HAS_DATA(HD),
                .AW(AW),
                .DW(DW)
            ) u_match (
                .mclk_i(mclk_i),
                .rst_i(rst_i),
                .ctl_i(ctl_q[g]),
                .cmp_addr_i({ah_q[g], am_q[g], al_q[g]}),
                .cmp_data_i(dat_q[g/2]),
                .cmp_mask_i(msk_q[g/2]),
                .bus_valid_i(bus_valid_i),
                .bus_addr_i(bus_addr_i),
                .bus_data_i(bus_data_i),
                .bus_read_i(bus_read_i),
                .bus_byte_i(bus_byte_i),
                .exec_valid_i(exec_valid_i),
                .exec_addr_i(exec_addr_i),
                .hit_o(hit[g])
            );
        end
    endgenerate

    // a channel with break set ends the session while armed
    always_comb begin
        brk_hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            brk_hit = brk_hit
                || (hit[i] && ctl_q[i][dcc_pkg::CTL_BRK]);
        end
        brk_hit = brk_hit && armed_o;
    end

    ////////////////////////////////////////////////////////////////////
    // triggers and breakpoint toward the sequencer and cpu
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            trigger_o <= 4'h0;
            break_o <= 1'b0;
        end else begin
            trigger_o <= armed_o ? hit : 4'h0;
            break_o <= brk_hit && brk_en_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sticky status, write-one clear, enable; a new event beats a clear
    logic [dcc_pkg::ST_W-1:0] ev, clr;
    always_comb begin
        ev = {brk_hit, armed_o ? hit : 4'h0};
        clr = '0;
        if (wr && lane0 && aligned && idx == dcc_pkg::IDX_IRQ_CLR) begin
            clr = pwdata_i[dcc_pkg::ST_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_en_q <= '0;
        end else if (wr && lane0 && aligned
                     && idx == dcc_pkg::IDX_IRQ_EN) begin
            irq_en_q <= pwdata_i[dcc_pkg::ST_W-1:0];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(((stat_q & ~clr) | ev) & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux
    logic [7:0] rd;
    always_comb begin
        rd = 8'h00;
        case (idx)
            dcc_pkg::IDX_CTL: rd = ctl_q[ch];
            dcc_pkg::IDX_AH: rd = {1'b0, ah_q[ch]};
            dcc_pkg::IDX_AM: rd = am_q[ch];
            dcc_pkg::IDX_AL: rd = al_q[ch];
            dcc_pkg::IDX_DH: rd = has_data ? dat_q[dch][15:8] : 8'h00;
            dcc_pkg::IDX_DL: rd = has_data ? dat_q[dch][7:0] : 8'h00;
            dcc_pkg::IDX_MH: rd = has_data ? msk_q[dch][15:8] : 8'h00;
            dcc_pkg::IDX_ML: rd = has_data ? msk_q[dch][7:0] : 8'h00;
            dcc_pkg::IDX_DBG_CTL: rd = {5'h00, armed_o, view_q};
            dcc_pkg::IDX_BRK_EN: rd = {7'h00, brk_en_q};
            dcc_pkg::IDX_IRQ_STAT: rd = {3'h0, stat_q};
            dcc_pkg::IDX_IRQ_EN: rd = {3'h0, irq_en_q};
            default: rd = 8'h00;
        endcase
        if (!aligned) begin
            rd = 8'h00;
        end
    end

    // one wait state: ready rises on the second access cycle, data with it
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_o) begin
            pready_o <= 1'b1;
            pslverr_o <= !mapped;
            prdata_o <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd};
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end
    end
endmodule : dcc_top

// ---- tb/dcc_top_props.sv ----
/* port checker for dcc_top: apb answer timing, trigger, arm and break.
   assumes the single clock mclk_i and the synchronous reset rst_i. */
`timescale 1ns/1ps
module dcc_top_props (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic bus_valid_i,
    input wire logic exec_valid_i,
    input wire logic [3:0] trigger_o,
    input wire logic break_o,
    input wire logic armed_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // apb answer shape
    a_ready_after_access: assert property (
        psel_i && penable_i && !pready_o |=> pready_o) else $error("no ready");
    a_ready_one_cycle: assert property (
        pready_o |=> !pready_o) else $error("ready too long");
    a_err_with_ready: assert property (
        pslverr_o |-> pready_o) else $error("error without ready");
    a_idle_data_zero: assert property (
        !pready_o |-> prdata_o == 32'h0) else $error("stray read data");
    a_high_bit_zero: assert property (
        pready_o && !pwrite_i && paddr_i == {2'h0, dcc_pkg::IDX_AH, 2'h0}
        |-> !prdata_o[7]) else $error("address high bit 7 set");
    // match outputs against their causes
    a_trig_needs_arm: assert property (
        trigger_o != 4'h0 |-> $past(armed_o)) else $error("trigger unarmed");
    a_trig_needs_bus: assert property (
        trigger_o != 4'h0 |-> $past(bus_valid_i, 2) || $past(exec_valid_i, 2))
        else $error("trigger without access");
    a_break_disarms: assert property (
        break_o |-> !armed_o) else $error("break left module armed");
endmodule : dcc_top_props
////////////////////////////////////////////////////////////////////////////
bind dcc_top dcc_top_props u_dcc_top_props (.mclk_i(mclk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .bus_valid_i(bus_valid_i),
    .exec_valid_i(exec_valid_i), .trigger_o(trigger_o), .break_o(break_o),
    .armed_o(armed_o));

// ---- tb/dcc_cpu.sv ----
/* cpu bus and execution stage as the comparators see them.
   assumes the bench calls cyc once per clock of activity. */
`timescale 1ns/1ps
module dcc_cpu (
    input wire logic mclk_i,
    output logic bus_valid_o,
    output logic [22:0] bus_addr_o,
    output logic [15:0] bus_data_o,
    output logic bus_read_o,
    output logic bus_byte_o,
    output logic exec_valid_o,
    output logic [22:0] exec_addr_o
);
    // quiet bus at time zero
    initial begin
        {bus_valid_o, bus_read_o, bus_byte_o, exec_valid_o} = 4'h0;
        {bus_addr_o, bus_data_o, exec_addr_o} = 62'h0;
    end
    // one clock of activity; released lines show the inverse of their
    // last value so a stale value never looks like a live one
    task automatic cyc(input logic v, e, input logic [22:0] a,
        input logic [15:0] d, input logic rd, by);
        @(posedge mclk_i);
        bus_valid_o <= v;
        exec_valid_o <= e;
        bus_addr_o <= v ? a : ~bus_addr_o;
        bus_data_o <= v ? d : ~bus_data_o;
        bus_read_o <= v ? rd : ~bus_read_o;
        bus_byte_o <= v ? by : ~bus_byte_o;
        exec_addr_o <= e ? a : ~exec_addr_o;
    endtask : cyc
endmodule : dcc_cpu

// ---- tb/tb_dcc_top.sv ----
/* self-checking bench for dcc_top with a reference model of the window,
   the match qualifiers, break and the interrupt status.
   assumes dcc_pkg, dcc_cpu and the port checker are compiled first. */
`timescale 1ns/1ps
module tb_dcc_top;
    logic mclk_i = 1'b0, rst_i = 1'b1;
    logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h0;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o, rd;
    logic pready_o, pslverr_o, bus_valid_i, bus_read_i, bus_byte_i, er;
    logic exec_valid_i, break_o, armed_o, irq_o;
    logic [22:0] bus_addr_i, exec_addr_i, a;
    logic [15:0] bus_data_i, d;
    logic [3:0] trigger_o, exp, seen;
    logic [7:0] m[4][8];
    logic [7:0] v;
    logic [4:0] stat = 5'h0;
    bit pend[4];
    int errors = 0, total_checks = 0, seed = 78, cyc_n = 0, c;
    dcc_top u_dcc_top (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o),
        .bus_valid_i(bus_valid_i), .bus_addr_i(bus_addr_i),
        .bus_data_i(bus_data_i), .bus_read_i(bus_read_i),
        .bus_byte_i(bus_byte_i), .exec_valid_i(exec_valid_i),
        .exec_addr_i(exec_addr_i), .trigger_o(trigger_o),
        .break_o(break_o), .armed_o(armed_o), .irq_o(irq_o));
    dcc_cpu u_dcc_cpu (.mclk_i(mclk_i), .bus_valid_o(bus_valid_i),
        .bus_addr_o(bus_addr_i), .bus_data_o(bus_data_i),
        .bus_read_o(bus_read_i), .bus_byte_o(bus_byte_i),
        .exec_valid_o(exec_valid_i), .exec_addr_o(exec_addr_i));
    initial forever #10 mclk_i = ~mclk_i;
    // hang guard
    always @(posedge mclk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 20000) begin
            errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] idx, wd);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= {2'h0, idx, 2'h0};
        pwdata_i <= {24'h0, wd};
        @(posedge mclk_i);
        penable_i <= 1'b1;
        // no cycle count assumed: only the hang guard ends a stuck wait
        do begin
            @(posedge mclk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    // what a window byte holds after a write
    function automatic logic [7:0] keep(int k, int r, logic [7:0] x);
        if (r > 3 && k[0]) return 8'h00;
        if (r == 1 || (r == 0 && !k[0])) return x & 8'h7f;
        return x;
    endfunction : keep
    // reference match of channel k for the access in a and d
    function automatic logic hitf(int k, logic bv, ev, r, b);
        logic [7:0] t;
        t = m[k][0];
        if (!t[0] || a != {m[k][1][6:0], m[k][2], m[k][3]}) return 1'b0;
        if (t[5]) begin
            if (ev && pend[k]) begin
                pend[k] = 1'b0;
                return 1'b1;
            end
            pend[k] = pend[k] | bv;
            return 1'b0;
        end
        if (!bv || (t[2] && t[3] != r)) return 1'b0;
        if (k[0]) return !t[7] || t[6] == b;
        return (((d ^ {m[k][4], m[k][5]}) & {m[k][6], m[k][7]}) != 0)
            == t[6];
    endfunction : hitf
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (8) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (c = 0; c < 4; c++) begin
            apb(1'b1, dcc_pkg::IDX_DBG_CTL, 8'(c));
            for (int r = 0; r < 8; r++) begin
                apb(1'b0, dcc_pkg::IDX_CTL + 8'(r), 8'h00);
                chk(rd, 32'h0);
                v = 8'($random(seed)) & (r == 0 ? 8'hed : 8'hff);
                if (r > 5) v = v & 8'($random(seed));
                apb(1'b1, dcc_pkg::IDX_CTL + 8'(r), v);
                m[c][r] = keep(c, r, v);
            end
            for (int r = 0; r < 8; r++) begin
                apb(1'b0, dcc_pkg::IDX_CTL + 8'(r), 8'h00);
                chk(rd, {24'h0, m[c][r]});
            end
        end
        apb(1'b1, dcc_pkg::IDX_DBG_CTL, 8'h04);
        #1 chk(armed_o, 1'b1);
        apb(1'b1, dcc_pkg::IDX_AH, 8'h55);
        apb(1'b0, dcc_pkg::IDX_AH, 8'h00);
        chk(rd, {24'h0, m[0][1]});
        apb(1'b0, 8'h3f, 8'h00);
        chk(er, 1'b1);
        $display("test registers done");
        repeat (400) begin
            c = $random(seed) & 3;
            a = {m[c][1][6:0], m[c][2], m[c][3]};
            if (($random(seed) & 7) == 0) a[0] = ~a[0];
            v = 8'($random(seed));
            d = {m[c][4], m[c][5]} ^ (16'($random(seed)) & 16'($random(seed)));
            for (int k = 0; k < 4; k++) begin
                exp[k] = hitf(k, v[0], !v[0] && v[1], v[2], v[3]);
            end
            u_dcc_cpu.cyc(v[0], !v[0] && v[1], a, d, v[2], v[3]);
            u_dcc_cpu.cyc(1'b0, 1'b0, a, d, 1'b0, 1'b0);
            seen = 4'h0;
            repeat (3) @(posedge mclk_i) #1 seen |= trigger_o;
            chk(seen, exp);
            stat[3:0] |= exp;
        end
        $display("test matching done");
        for (int b = 1; b >= 0; b--) begin
            apb(1'b1, dcc_pkg::IDX_DBG_CTL, 8'h00);
            apb(1'b1, dcc_pkg::IDX_CTL, 8'h11);
            apb(1'b1, dcc_pkg::IDX_MH, 8'h00);
            apb(1'b1, dcc_pkg::IDX_ML, 8'h00);
            apb(1'b1, dcc_pkg::IDX_BRK_EN, 8'(b));
            apb(1'b1, dcc_pkg::IDX_DBG_CTL, 8'h04);
            a = {m[0][1][6:0], m[0][2], m[0][3]};
            u_dcc_cpu.cyc(1'b1, 1'b0, a, 16'h0, 1'b1, 1'b0);
            u_dcc_cpu.cyc(1'b0, 1'b0, a, 16'h0, 1'b0, 1'b0);
            seen = 4'h0;
            repeat (5) @(posedge mclk_i) #1 seen[0] |= break_o;
            chk(seen, 32'(b));
            // the break disarms whether or not breakpoints are enabled
            chk(armed_o, 1'b0);
            stat |= {1'b1, 4'h1};
        end
        $display("test break done");
        apb(1'b1, dcc_pkg::IDX_IRQ_EN, 8'h00);
        @(posedge mclk_i) #1 chk(irq_o, 1'b0);
        apb(1'b1, dcc_pkg::IDX_IRQ_EN, 8'h1f);
        @(posedge mclk_i) #1 chk(irq_o, 1'b1);
        apb(1'b0, dcc_pkg::IDX_IRQ_STAT, 8'h00);
        chk(rd, {27'h0, stat});
        apb(1'b1, dcc_pkg::IDX_IRQ_CLR, 8'h1f);
        apb(1'b0, dcc_pkg::IDX_IRQ_STAT, 8'h00);
        chk(rd, 32'h0);
        chk(irq_o, 1'b0);
        $display("test interrupt done");
        tally_and_finish();
    end
endmodule : tb_dcc_top
